// ==== logic/mir_params.svh ====
/*
 Constants of the interrupt request logic: register map, field positions,
 edge codes, vector numbering and default sizes.
 Assumes it is included by the package and by the controller module.
*/
// Function
// - Pin edge of chosen type sets external flag
// - External vector needs global, pin enable, stack room
// - Pin active only if enabled, routed, input
// - External service clears its flag and global enable
// - Pull-high selection stays valid on interrupt pins
// - Edge select picks rising, falling, both or off
// - Up to ten shared interrupts merge peripheral sources
// - Shared flag sets when a member source flag sets
// - Shared service clears shared flag and global enable
// - Converter done flag sets on conversion end
// - Converter vector gated; service clears flag, global enable
// - Each timer gives A-match and P-match flags, enables
// - Shared source vectors need global, source, shared enables
// - Low supply report sets low supply flag
// - EEPROM write end sets its flag
// - Serial one: byte, address match or timeout
// - Serial two flag sets on each byte
// - Any flag rising wakes the device, enabled or not
`ifndef MIR_PARAMS_SVH
`define MIR_PARAMS_SVH

`define MIR_ADDR_W        12
`define MIR_OFS_GIE       12'h000
`define MIR_OFS_EXT_CTRL  12'h004
`define MIR_OFS_EDGE      12'h008
`define MIR_OFS_EXT_FLAG  12'h00c
`define MIR_OFS_CONV      12'h010
`define MIR_OFS_SRC_EN    12'h014
`define MIR_OFS_SRC_FLAG  12'h018
`define MIR_OFS_MF_EN     12'h01c
`define MIR_OFS_MF_FLAG   12'h020
`define MIR_OFS_PEND      12'h024

`define MIR_GIE_BIT       0
`define MIR_PULL_LSB      8
`define MIR_CONV_EN_BIT   0
`define MIR_CONV_FLAG_BIT 1
`define MIR_PEND_ST_BIT   4

`define MIR_NUM_EXT       4
`define MIR_NUM_MF        10
`define MIR_NUM_TM        2
`define MIR_MISC_SRCS     4
`define MIR_SRC_LOW       0
`define MIR_SRC_EE        1
`define MIR_SRC_SER1      2
`define MIR_SRC_SER2      3

`define MIR_EDGE_OFF      2'h0
`define MIR_EDGE_RISE     2'h1
`define MIR_EDGE_FALL     2'h2
`define MIR_EDGE_BOTH     2'h3
`define MIR_EDGE_RISE_BIT 0
`define MIR_EDGE_FALL_BIT 1

`define MIR_VEC_CONV      4
`define MIR_VEC_MF0       5

`endif

// ==== logic/mir_pkg.sv ====
/*
 Types of the interrupt request logic.
 Assumes mir_params.svh is on the include path.
*/
`include "mir_params.svh"

package mir_pkg;
   typedef enum logic [0:0] {
      MIR_IDLE = 1'h0,
      MIR_REQ  = 1'h1
   } mir_state_t;

   typedef logic [3:0] mir_vec_t;
   typedef logic [1:0] mir_edge_t;
endpackage

// ==== logic/mir_irq_ctrl.sv ====
/*
 Interrupt request logic: four edge-triggered external pins, a converter
 done interrupt and shared interrupts merging timer, supply, EEPROM and
 serial requests; vector request to the core with acknowledge; APB slave.
 Assumes all inputs synchronous to sys_clk, event inputs one cycle pulses,
 and the core pulses core_ack once per taken vector.
*/
`timescale 1ns/100ps
`include "mir_params.svh"

module mir_irq_ctrl
   import mir_pkg::*;
#(
   parameter int NUM_MF = `MIR_NUM_MF,
   parameter int NUM_TM = `MIR_NUM_TM
)
(
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      sys_rst,
   // APB slave
   input  wire logic [`MIR_ADDR_W-1:0]    paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // External pins and their pin setup
   input  wire logic [`MIR_NUM_EXT-1:0]   ext_irq_pins,
   input  wire logic [`MIR_NUM_EXT-1:0]   pin_share_sel,
   input  wire logic [`MIR_NUM_EXT-1:0]   port_dir_in,
   output logic      [`MIR_NUM_EXT-1:0]   pull_up_en,
   // Peripheral events
   input  wire logic                      conv_done,
   input  wire logic [NUM_TM-1:0]         tm_match_a,
   input  wire logic [NUM_TM-1:0]         tm_match_p,
   input  wire logic                      low_supply_det,
   input  wire logic                      eeprom_write_end,
   input  wire logic                      ser1_byte_done,
   input  wire logic                      ser1_addr_match,
   input  wire logic                      ser1_bus_timeout,
   input  wire logic                      ser2_byte_done,
   // Core side
   input  wire logic                      stack_full,
   input  wire logic                      core_ack,
   output logic                           irq_req,
   output mir_vec_t                       irq_vec,
   output logic                           wake
);

   localparam int NUM_SRC = 2 * NUM_TM + `MIR_MISC_SRCS;
   localparam int NV      = `MIR_VEC_MF0 + NUM_MF;
   localparam int NX      = `MIR_NUM_EXT;

   mir_state_t            state;
   logic                  global_irq_enable;
   logic [NX-1:0]         ext_enable_bits;
   logic [NX-1:0]         ext_request_flags;
   logic [2*NX-1:0]       edge_select_reg;
   logic                  conv_done_enable;
   logic                  conv_done_flag;
   logic [NUM_SRC-1:0]    src_enable;
   logic [NUM_SRC-1:0]    src_flag;
   logic [NUM_MF-1:0]     shared_enable_bit;
   logic [NUM_MF-1:0]     shared_request_flag;
   logic [NX-1:0]         pin_q;
   logic                  pin_q_vld;
   logic [NX-1:0]         ext_active;
   logic [NX-1:0]         ext_evt;
   logic [NUM_SRC-1:0]    src_evt;
   logic [NUM_SRC-1:0]    src_new;
   logic [NUM_MF-1:0]     mf_set;
   logic [NV-1:0]         cand;
   logic                  cand_ok;
   mir_vec_t              best_vec;
   logic                  ack_fire;
   logic                  wr_en;
   logic [31:0]           rd_val;
   logic                  rd_err;
   logic [NV+NUM_SRC-1:0] all_flags;
   logic [NV+NUM_SRC-1:0] flags_q;

   // Any flag of the sources mapped onto shared interrupt m
   function automatic logic mf_hit(input logic [NUM_SRC-1:0] v, input int m);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         if (i % NUM_MF == m)
            r = r | v[i];
      end
      return r;
   endfunction

   function automatic mir_vec_t pick_lowest(input logic [NV-1:0] c);
      mir_vec_t r;
      r = '0;
      for (int i = NV - 1; i >= 0; i--)
      begin
         if (c[i])
            r = 4'(i);
      end
      return r;
   endfunction

   // APB: one wait state per access, data registered on the same edge as pready
   assign wr_en    = psel & penable & pready & pwrite;
   assign ack_fire = (state == MIR_REQ) & core_ack;

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & rd_err;
         if (psel & penable & ~pready & ~pwrite)
            prdata <= rd_val;
      end
   end

   always_comb
   begin
      rd_val = '0;
      rd_err = 1'b0;
      case (paddr)
         `MIR_OFS_GIE:      rd_val[`MIR_GIE_BIT] = global_irq_enable;
         `MIR_OFS_EXT_CTRL:
         begin
            rd_val[NX-1:0] = ext_enable_bits;
            rd_val[`MIR_PULL_LSB +: NX] = pull_up_en;
         end
         `MIR_OFS_EDGE:     rd_val[2*NX-1:0] = edge_select_reg;
         `MIR_OFS_EXT_FLAG: rd_val[NX-1:0] = ext_request_flags;
         `MIR_OFS_CONV:
         begin
            rd_val[`MIR_CONV_EN_BIT]   = conv_done_enable;
            rd_val[`MIR_CONV_FLAG_BIT] = conv_done_flag;
         end
         `MIR_OFS_SRC_EN:   rd_val[NUM_SRC-1:0] = src_enable;
         `MIR_OFS_SRC_FLAG: rd_val[NUM_SRC-1:0] = src_flag;
         `MIR_OFS_MF_EN:    rd_val[NUM_MF-1:0] = shared_enable_bit;
         `MIR_OFS_MF_FLAG:  rd_val[NUM_MF-1:0] = shared_request_flag;
         `MIR_OFS_PEND:
         begin
            rd_val[3:0] = irq_vec;
            rd_val[`MIR_PEND_ST_BIT] = state;
         end
         default:           rd_err = 1'b1;
      endcase
   end

   // Plain control registers
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         ext_enable_bits   <= '0;
         pull_up_en        <= '0;
         edge_select_reg   <= '0;
         conv_done_enable  <= 1'b0;
         src_enable        <= '0;
         shared_enable_bit <= '0;
      end
      else if (wr_en)
      begin
         case (paddr)
            `MIR_OFS_EXT_CTRL:
            begin
               ext_enable_bits <= pwdata[NX-1:0];
               pull_up_en      <= pwdata[`MIR_PULL_LSB +: NX];
            end
            `MIR_OFS_EDGE:    edge_select_reg   <= pwdata[2*NX-1:0];
            `MIR_OFS_CONV:    conv_done_enable  <= pwdata[`MIR_CONV_EN_BIT];
            `MIR_OFS_SRC_EN:  src_enable        <= pwdata[NUM_SRC-1:0];
            `MIR_OFS_MF_EN:   shared_enable_bit <= pwdata[NUM_MF-1:0];
            default:          ;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         global_irq_enable <= 1'b0;
      else if (ack_fire)
         global_irq_enable <= 1'b0;
      else if (wr_en && paddr == `MIR_OFS_GIE)
         global_irq_enable <= pwdata[`MIR_GIE_BIT];
   end

   // Edges ignored until a first pin sample exists
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pin_q     <= '0;
         pin_q_vld <= 1'b0;
      end
      else
      begin
         pin_q     <= ext_irq_pins;
         pin_q_vld <= 1'b1;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NX; i++)
      begin
         ext_active[i] = ext_enable_bits[i] & pin_share_sel[i] & port_dir_in[i]
                         & (edge_select_reg[2*i +: 2] != `MIR_EDGE_OFF);
         ext_evt[i] = ext_active[i] & pin_q_vld
            & ((ext_irq_pins[i] & ~pin_q[i] & edge_select_reg[2*i+`MIR_EDGE_RISE_BIT])
             | (~ext_irq_pins[i] & pin_q[i] & edge_select_reg[2*i+`MIR_EDGE_FALL_BIT]));
      end
   end

   // set wins over service and software clear
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         ext_request_flags <= '0;
      else
      begin
         for (int i = 0; i < NX; i++)
         begin
            if (ext_evt[i])
               ext_request_flags[i] <= 1'b1;
            else if ((ack_fire && irq_vec == 4'(i))
                     || (wr_en && paddr == `MIR_OFS_EXT_FLAG && pwdata[i]))
               ext_request_flags[i] <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         conv_done_flag <= 1'b0;
      else if (conv_done)
         conv_done_flag <= 1'b1;
      else if ((ack_fire && irq_vec == 4'(`MIR_VEC_CONV))
               || (wr_en && paddr == `MIR_OFS_CONV && pwdata[`MIR_CONV_FLAG_BIT]))
         conv_done_flag <= 1'b0;
   end

   always_comb
   begin
      src_evt = '0;
      for (int t = 0; t < NUM_TM; t++)
      begin
         src_evt[2*t]   = tm_match_a[t];
         src_evt[2*t+1] = tm_match_p[t];
      end
      src_evt[2*NUM_TM+`MIR_SRC_LOW]  = low_supply_det;
      src_evt[2*NUM_TM+`MIR_SRC_EE]   = eeprom_write_end;
      src_evt[2*NUM_TM+`MIR_SRC_SER1] = ser1_byte_done | ser1_addr_match
                                        | ser1_bus_timeout;
      src_evt[2*NUM_TM+`MIR_SRC_SER2] = ser2_byte_done;
      src_new = src_evt & ~src_flag;
      for (int m = 0; m < NUM_MF; m++)
      begin
         mf_set[m] = mf_hit(src_new, m);
      end
   end

   // source flags cleared by software only
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         src_flag <= '0;
      else if (wr_en && paddr == `MIR_OFS_SRC_FLAG)
         src_flag <= (src_flag & ~pwdata[NUM_SRC-1:0]) | src_evt;
      else
         src_flag <= src_flag | src_evt;
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         shared_request_flag <= '0;
      else
      begin
         for (int m = 0; m < NUM_MF; m++)
         begin
            if (mf_set[m])
               shared_request_flag[m] <= 1'b1;
            else if ((ack_fire && irq_vec == 4'(`MIR_VEC_MF0 + m))
                     || (wr_en && paddr == `MIR_OFS_MF_FLAG && pwdata[m]))
               shared_request_flag[m] <= 1'b0;
         end
      end
   end

   always_comb
   begin
      cand_ok = global_irq_enable & ~stack_full;
      cand    = '0;
      for (int i = 0; i < NX; i++)
         cand[i] = ext_request_flags[i] & ext_enable_bits[i];
      cand[`MIR_VEC_CONV] = conv_done_flag & conv_done_enable;
      for (int m = 0; m < NUM_MF; m++)
      begin
         cand[`MIR_VEC_MF0+m] = shared_request_flag[m] & shared_enable_bit[m]
                                & mf_hit(src_flag & src_enable, m);
      end
      best_vec = pick_lowest(cand);
   end

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         state   <= MIR_IDLE;
         irq_req <= 1'b0;
         irq_vec <= '0;
      end
      else
      begin
         unique case (state)
            MIR_IDLE:
            begin
               if (cand_ok && |cand)
               begin
                  state   <= MIR_REQ;
                  irq_req <= 1'b1;
                  irq_vec <= best_vec;
               end
            end
            MIR_REQ:
            begin
               // Withdraw if the cause vanished before the core took it
               if (core_ack || !(cand_ok && cand[irq_vec]))
               begin
                  state   <= MIR_IDLE;
                  irq_req <= 1'b0;
               end
            end
         endcase
      end
   end

   // wake on any flag rise, enables ignored
   assign all_flags = {shared_request_flag, src_flag, conv_done_flag, ext_request_flags};

   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         flags_q <= '0;
         wake    <= 1'b0;
      end
      else
      begin
         flags_q <= all_flags;
         wake    <= |(all_flags & ~flags_q);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_grant;
      state == MIR_REQ && core_ack;
   endsequence

   sequence s_new_req;
      !irq_req ##1 irq_req;
   endsequence

   gie_cleared_a: assert property (s_grant |=> !global_irq_enable ##1 !irq_req)
      else $error("global enable not cleared after service");
   req_gated_a: assert property (s_new_req |-> $past(cand_ok))
      else $error("request raised without global enable or with full stack");
   prio_lowest_a: assert property (s_new_req |-> irq_vec == $past(best_vec))
      else $error("vector is not the lowest pending one");
   pin_gate_a: assert property ($rose(ext_request_flags[0]) |-> $past(ext_active[0]))
      else $error("external flag set on an inactive pin");
   edge_rise_a: assert property (ext_active[0] && pin_q_vld
      && edge_select_reg[1:0] == `MIR_EDGE_RISE && $rose(ext_irq_pins[0])
      |=> ext_request_flags[0])
      else $error("rising edge did not set external flag");
   conv_set_a: assert property (conv_done |=> conv_done_flag)
      else $error("conversion end did not set its flag");
   mf_merge_a: assert property (src_new[0] |=> shared_request_flag[0])
      else $error("shared flag missed a member source");
   src_kept_a: assert property ((s_grant and (irq_vec == 4'(`MIR_VEC_MF0)
      && src_flag[0] && !wr_en)) |=> src_flag[0])
      else $error("service cleared a source flag");
   wake_rise_a: assert property ($rose(conv_done_flag) |=> wake)
      else $error("flag rise gave no wake pulse");

endmodule

// ==== sim/mir_core_model.sv ====
/*
 Processor core model: takes an offered vector after a set delay if it is still requested.
 Assumes irq_req and irq_vec are registered and stable until acknowledged or withdrawn.
*/
`timescale 1ns/100ps

module mir_core_model
   import mir_pkg::*;
(
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Vector request
   input  wire logic       irq_req,
   input  wire mir_vec_t   irq_vec,
   input  wire logic [3:0] ack_delay,
   output logic            core_ack,
   // Record of taken vectors
   output mir_vec_t        taken_vec,
   output int              taken_cnt
);
   initial
   begin
      core_ack  = 1'b0;
      taken_vec = '0;
      taken_cnt = 0;
      forever
      begin
         @(posedge sys_clk);
         if (irq_req === 1'b1 && sys_rst === 1'b0)
         begin
            repeat (ack_delay) @(posedge sys_clk);
            // A slow core may find the request withdrawn
            if (irq_req === 1'b1)
            begin
               core_ack  <= 1'b1;
               taken_vec <= irq_vec;
               taken_cnt <= taken_cnt + 1;
               @(posedge sys_clk);
               core_ack <= 1'b0;
            end
         end
      end
   end
endmodule

// ==== sim/mir_irq_ctrl_tb_top.sv ====
/*
 Self-checking bench of the interrupt request logic, APB master tasks.
 Assumes mir_core_model answers on the core side.
*/
`timescale 1ns/100ps
`include "mir_params.svh"

module mir_irq_ctrl_tb_top
   import mir_pkg::*;
;
   logic                   sys_clk = 1'b0;
   logic                   sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [`MIR_ADDR_W-1:0] paddr;
   logic [31:0]            pwdata, prdata, rd;
   logic [3:0]             pins, share, dir_in, pull_up_en, ack_delay;
   logic [10:0]            evt;
   logic                   stack_full, core_ack, irq_req, wake;
   mir_vec_t               irq_vec, taken_vec;
   int                     taken_cnt;
   int                     wake_cnt = 0;
   int                     cyc = 0;
   int                     bad_count = 0;
   int                     num_checks = 0;
   // Source bit raised by each event input index from 1 up; index 0 (conv_done) raises none
   int                     src_map [11] = '{0, 0, 2, 1, 3, 4, 5, 6, 6, 6, 7};

   always #12.5 sys_clk = ~sys_clk;

   mir_irq_ctrl u_mir_irq_ctrl (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_irq_pins(pins),
      .pin_share_sel(share), .port_dir_in(dir_in), .pull_up_en(pull_up_en),
      .conv_done(evt[0]), .tm_match_a(evt[2:1]), .tm_match_p(evt[4:3]),
      .low_supply_det(evt[5]), .eeprom_write_end(evt[6]), .ser1_byte_done(evt[7]),
      .ser1_addr_match(evt[8]), .ser1_bus_timeout(evt[9]), .ser2_byte_done(evt[10]),
      .stack_full(stack_full), .core_ack(core_ack), .irq_req(irq_req),
      .irq_vec(irq_vec), .wake(wake));

   mir_core_model u_mir_core_model (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .irq_req(irq_req), .irq_vec(irq_vec),
      .ack_delay(ack_delay), .core_ack(core_ack), .taken_vec(taken_vec),
      .taken_cnt(taken_cnt));

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (wake === 1'b1)
         wake_cnt <= wake_cnt + 1;
      // Whole run needs a few hundred cycles
      if (cyc == 20000)
      begin
         bad_count = bad_count + 1;
         end_of_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string w);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t %s: got %h exp %h", $time, w, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel   <= 1'b1;
      paddr  <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      // Only the bench timeout ends a wait for the slave
      while (pready !== 1'b1)
      begin
         @(posedge sys_clk);
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string w);
      apb(1'b0, a, 32'h0);
      chk(rd, e, w);
   endtask

   task automatic setpin(input logic [3:0] v);
      @(posedge sys_clk);
      pins <= v;
      tick(3);
   endtask

   task automatic pulse(input int k);
      @(posedge sys_clk);
      evt <= 11'h1 << k;
      @(posedge sys_clk);
      evt <= '0;
      tick(3);
   endtask

   task automatic take(input mir_vec_t v, input string w);
      int c0;
      int n;
      c0 = taken_cnt;
      n = 0;
      while (taken_cnt == c0 && n < 50)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(n < 50), 32'h1, w);
      chk(32'(taken_vec), 32'(v), w);
      tick(2);
   endtask

   task automatic t_reset;
      rdc(`MIR_OFS_GIE, 32'h0, "gie reset");
      rdc(`MIR_OFS_EXT_CTRL, 32'h0, "ext ctrl reset");
      rdc(`MIR_OFS_MF_FLAG, 32'h0, "shared flag reset");
      rdc(`MIR_OFS_PEND, 32'h0, "pending reset");
      apb(1'b0, 12'hffc, 32'h0);
      chk(32'(err), 32'h1, "unmapped error");
      chk(rd, 32'h0, "unmapped data");
   endtask

   task automatic t_edges;
      int c;
      apb(1'b1, `MIR_OFS_EXT_CTRL, 32'h0f0f);
      tick(1);
      chk(32'(pull_up_en), 32'hf, "pull high");
      for (c = 0; c < 4; c++)
      begin
         apb(1'b1, `MIR_OFS_EDGE, 32'(c));
         setpin(4'h1);
         rdc(`MIR_OFS_EXT_FLAG, 32'(c & 1), "rise edge");
         apb(1'b1, `MIR_OFS_EXT_FLAG, 32'hf);
         setpin(4'h0);
         rdc(`MIR_OFS_EXT_FLAG, 32'((c >> 1) & 1), "fall edge");
         apb(1'b1, `MIR_OFS_EXT_FLAG, 32'hf);
      end
      share <= 4'he;
      setpin(4'h1);
      rdc(`MIR_OFS_EXT_FLAG, 32'h0, "not routed");
      share  <= 4'hf;
      dir_in <= 4'he;
      setpin(4'h0);
      rdc(`MIR_OFS_EXT_FLAG, 32'h0, "not input");
      dir_in <= 4'hf;
      apb(1'b1, `MIR_OFS_EXT_CTRL, 32'h0f0e);
      setpin(4'h1);
      rdc(`MIR_OFS_EXT_FLAG, 32'h0, "pin disabled");
      chk(32'(pull_up_en), 32'hf, "pull kept");
      apb(1'b1, `MIR_OFS_EXT_CTRL, 32'h0f0f);
      setpin(4'h0);
      rdc(`MIR_OFS_EXT_FLAG, 32'h1, "pin enabled");
      apb(1'b1, `MIR_OFS_EXT_FLAG, 32'hf);
   endtask

   task automatic t_ext_service;
      apb(1'b1, `MIR_OFS_EDGE, 32'hff);
      @(posedge sys_clk);
      stack_full <= 1'b1;
      apb(1'b1, `MIR_OFS_GIE, 32'h1);
      setpin(4'h8);
      tick(5);
      chk(32'(irq_req), 32'h0, "stack full");
      @(posedge sys_clk);
      stack_full <= 1'b0;
      take(4'h3, "ext vector");
      rdc(`MIR_OFS_EXT_FLAG, 32'h0, "ext flag cleared");
      rdc(`MIR_OFS_GIE, 32'h0, "gie cleared");
      setpin(4'h0);
      apb(1'b1, `MIR_OFS_EXT_FLAG, 32'hf);
   endtask

   task automatic t_conv_prio;
      apb(1'b1, `MIR_OFS_CONV, 32'h1);
      setpin(4'h4);
      pulse(0);
      rdc(`MIR_OFS_CONV, 32'h3, "conv flag");
      ack_delay <= 4'h5;
      apb(1'b1, `MIR_OFS_GIE, 32'h1);
      take(4'h2, "lowest first");
      rdc(`MIR_OFS_CONV, 32'h3, "conv pending");
      apb(1'b1, `MIR_OFS_GIE, 32'h1);
      take(4'h4, "conv vector");
      rdc(`MIR_OFS_CONV, 32'h1, "conv cleared");
      rdc(`MIR_OFS_GIE, 32'h0, "gie cleared");
      ack_delay <= 4'h0;
      setpin(4'h0);
      apb(1'b1, `MIR_OFS_EXT_FLAG, 32'hf);
   endtask

   task automatic t_shared;
      int k;
      int w0;
      for (k = 1; k < 11; k++)
      begin
         apb(1'b1, `MIR_OFS_SRC_FLAG, 32'hff);
         apb(1'b1, `MIR_OFS_MF_FLAG, 32'h3ff);
         w0 = wake_cnt;
         pulse(k);
         rdc(`MIR_OFS_SRC_FLAG, 32'h1 << src_map[k], "source flag");
         rdc(`MIR_OFS_MF_FLAG, 32'h1 << src_map[k], "shared flag");
         chk(32'(wake_cnt > w0), 32'h1, "wake");
      end
      apb(1'b1, `MIR_OFS_SRC_FLAG, 32'hff);
      apb(1'b1, `MIR_OFS_MF_FLAG, 32'h3ff);
      pulse(1);
      apb(1'b1, `MIR_OFS_SRC_EN, 32'h1);
      apb(1'b1, `MIR_OFS_GIE, 32'h1);
      tick(4);
      chk(32'(irq_req), 32'h0, "shared enable off");
      apb(1'b1, `MIR_OFS_MF_EN, 32'h1);
      take(4'h5, "shared vector");
      rdc(`MIR_OFS_MF_FLAG, 32'h0, "shared cleared");
      rdc(`MIR_OFS_SRC_FLAG, 32'h1, "source kept");
      rdc(`MIR_OFS_GIE, 32'h0, "gie cleared");
      apb(1'b1, `MIR_OFS_SRC_FLAG, 32'hff);
      rdc(`MIR_OFS_SRC_FLAG, 32'h0, "source cleared");
   endtask

   initial
   begin
      sys_rst    = 1'b1;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = '0;
      pwdata     = '0;
      pins       = '0;
      share      = 4'hf;
      dir_in     = 4'hf;
      evt        = '0;
      stack_full = 1'b0;
      ack_delay  = '0;
      tick(5);
      sys_rst <= 1'b0;
      t_reset();
      t_edges();
      t_ext_service();
      t_conv_prio();
      t_shared();
      end_of_test();
   end
endmodule
